// ---- clock_reset_power_control.sv ----
`timescale 1ns/1ps
`include "crpc_defines.svh"
// Summary of operation
// - flash wait states: 0 up to 24 MHz, 1 up to 48, else 2
// - boot source chosen at startup from boot pin and option bit
// - whole block held in reset while the reset pin is low
// - reset pin pulled up; floating or high ends reset
// - sleep gates only the cpu clock; any interrupt or event wakes
// - stop gates all core clocks, disables pll and both oscillators
// - regulator may be normal or low power during stop
// - any external event line wakes the device from stop
// - rtc, watchdog and their clock sources keep running in stop
// - internal rc oscillator is the cpu clock after reset
// - external clock selectable and monitored while in use
// - on external clock failure hardware falls back to rc
// - clock failure interrupt raised only when enabled
// - pll input clock failure also reported by interrupt
// - prescalers derive ahb, fast apb (72 MHz) and slow apb (36 MHz)
// - advanced timer clock may run up to 144 MHz
module clock_reset_power_control
    import crpc_pkg::*;
(
    // clock and synchronous reset
    input wire logic sys_clk,
    input wire logic rst,
    // reset pin, already resolved with its pull-up
    input wire logic power_on_reset_pin_n,
    // boot straps
    input wire logic boot_select_pin,
    input wire logic boot_option_bit,
    // clock selection and configuration
    input wire logic [1:0] sw_clk_sel,
    input wire logic [7:0] ext_clk_mhz,
    input wire logic [7:0] pll_clk_mhz,
    input wire logic pll_src_ext,
    input wire logic [3:0] ahb_div,
    input wire logic [3:0] apb_fast_div,
    input wire logic [3:0] apb_slow_div,
    input wire logic fail_irq_en,
    input wire logic fail_clr,
    // oscillator status from analog
    input wire logic ext_osc_clk,
    input wire logic rc_osc_ready,
    // power mode requests
    input wire logic sleep_req,
    input wire logic stop_req,
    input wire logic stop_lp_regulator,
    input wire logic irq_or_event,
    input wire logic [`WAKE_LINES-1:0] external_event_lines,
    // reset and boot outputs
    output logic core_rst,
    output boot_src_e boot_src,
    // clock outputs
    output clk_src_e sys_clk_src,
    output clk_en_s clk_en,
    output logic [1:0] flash_wait,
    output logic [7:0] cpu_mhz,
    // oscillator and regulator controls
    output logic rc_osc_on,
    output logic ext_osc_on,
    output logic pll_on,
    output logic lsclk_on,
    output logic regulator_lp,
    // status
    output pwr_state_e pwr_state,
    output logic clk_fail_flag,
    output logic clk_fail_irq
);
    // pin synchronisers; first stages are read only by the second
    logic por_s1_q, por_s2_q, ext_s1_q, ext_s2_q, ext_s3_q;
    logic [`WAKE_LINES-1:0] ev_s1_q, ev_s2_q;
    logic boot_s1_q, boot_s2_q, rc_s1_q, rc_s2_q;

    always_ff @(posedge sys_clk) begin
        por_s1_q <= power_on_reset_pin_n;
        por_s2_q <= por_s1_q;
        ext_s1_q <= ext_osc_clk;
        ext_s2_q <= ext_s1_q;
        ext_s3_q <= ext_s2_q;
        ev_s1_q <= external_event_lines;
        ev_s2_q <= ev_s1_q;
        boot_s1_q <= boot_select_pin;
        boot_s2_q <= boot_s1_q;
        rc_s1_q <= rc_osc_ready;
        rc_s2_q <= rc_s1_q;
    end

    // internal reset while pin low; pin high or floating releases
    logic any_rst;
    assign any_rst = rst | ~por_s2_q;
    assign core_rst = any_rst;

    // boot strap capture at reset release
    boot_src_e boot_q, boot_d;
    logic boot_done_q, boot_done_d;

    always_comb begin
        boot_d = boot_q;
        boot_done_d = boot_done_q;
        if (!boot_done_q) begin
            boot_done_d = 1'b1;
            if (!boot_s2_q) begin
                boot_d = BOOT_FLASH;
            end else if (!boot_option_bit) begin
                boot_d = BOOT_SRAM;
            end else begin
                boot_d = BOOT_SYSMEM;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (any_rst) begin
            boot_q <= BOOT_FLASH;
            boot_done_q <= 1'b0;
        end else begin
            boot_q <= boot_d;
            boot_done_q <= boot_done_d;
        end
    end
    assign boot_src = boot_q;

    // external clock monitor: timeout with no edge means failure
    logic [7:0] mon_cnt_q, mon_cnt_d;
    logic ext_fail;
    logic ext_edge;
    assign ext_edge = ext_s2_q ^ ext_s3_q;
    assign ext_fail = (mon_cnt_q >= `EXT_MON_TIMEOUT);

    always_comb begin
        mon_cnt_d = mon_cnt_q;
        if (!ext_osc_on || ext_edge) begin
            mon_cnt_d = 8'h00;
        end else if (!ext_fail) begin
            mon_cnt_d = mon_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (any_rst) begin
            mon_cnt_q <= 8'h00;
        end else begin
            mon_cnt_q <= mon_cnt_d;
        end
    end

    // power mode state machine
    pwr_state_e pwr_q, pwr_d;
    logic [15:0] settle_q, settle_d;
    logic wake_ev;
    assign wake_ev = |ev_s2_q;

    always_comb begin
        pwr_d = pwr_q;
        settle_d = settle_q;
        case (pwr_q)
            PWR_RUN: begin
                if (stop_req) begin
                    pwr_d = PWR_STOP;
                end else if (sleep_req) begin
                    pwr_d = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (irq_or_event || wake_ev) begin
                    pwr_d = PWR_RUN;
                end
            end
            PWR_STOP: begin
                if (wake_ev) begin
                    pwr_d = PWR_WAKE;
                    settle_d = 16'h0000;
                end
            end
            PWR_WAKE: begin
                if (rc_s2_q &&
                    settle_q >= 16'(`RC_SETTLE_CYC - 1)) begin
                    pwr_d = PWR_RUN;
                end else if (settle_q < 16'(`RC_SETTLE_CYC - 1)) begin
                    settle_d = settle_q + 16'h0001;
                end
            end
            default: pwr_d = PWR_RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (any_rst) begin
            pwr_q <= PWR_RUN;
            settle_q <= 16'h0000;
        end else begin
            pwr_q <= pwr_d;
            settle_q <= settle_d;
        end
    end
    assign pwr_state = pwr_q;

    // clock source selection with hardware fallback to rc
    clk_src_e src_q, src_d;
    logic fail_q, fail_d;
    logic [7:0] src_mhz, tgt_mhz;
    logic [1:0] ws_q, ws_d, ws_need_tgt;

    // source frequency of a candidate source
    function automatic logic [7:0] mhz_of(input clk_src_e s,
                                          input logic [7:0] ext_m,
                                          input logic [7:0] pll_m);
        case (s)
            SRC_EXT: mhz_of = ext_m;
            SRC_PLL: mhz_of = pll_m;
            default: mhz_of = `RC_OSC_MHZ;
        endcase
    endfunction

    // wait states needed for a cpu frequency
    function automatic logic [1:0] ws_for(input logic [7:0] m);
        if (m <= `WS0_MAX_MHZ) begin
            ws_for = 2'd0;
        end else if (m <= `WS1_MAX_MHZ) begin
            ws_for = 2'd1;
        end else begin
            ws_for = 2'd2;
        end
    endfunction

    logic ext_used;
    assign ext_used = (src_q == SRC_EXT) || (src_q == SRC_PLL && pll_src_ext);
    assign tgt_mhz = mhz_of(clk_src_e'(sw_clk_sel), ext_clk_mhz, pll_clk_mhz);
    assign ws_need_tgt = ws_for(tgt_mhz);

    // switch only once wait states cover both old and new frequency
    always_comb begin
        src_d = src_q;
        fail_d = fail_q;
        ws_d = ws_q;
        if (fail_clr) begin
            fail_d = 1'b0;
        end
        if (ext_used && ext_fail) begin
            src_d = SRC_RC;
            fail_d = 1'b1; // set wins over clear
        end else if (pwr_q == PWR_STOP || pwr_q == PWR_WAKE) begin
            src_d = SRC_RC;
        end else if (sw_clk_sel != 2'd3 && clk_src_e'(sw_clk_sel) != src_q
                     && !fail_q) begin
            if (ws_q < ws_need_tgt) begin
                ws_d = ws_need_tgt;
            end else begin
                src_d = clk_src_e'(sw_clk_sel);
            end
        end else if (ws_q > ws_for(src_mhz)) begin
            ws_d = ws_for(src_mhz);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (any_rst) begin
            src_q <= SRC_RC;
            fail_q <= 1'b0;
            ws_q <= 2'd0;
        end else begin
            src_q <= src_d;
            fail_q <= fail_d;
            ws_q <= ws_d;
        end
    end
    assign src_mhz = mhz_of(src_q, ext_clk_mhz, pll_clk_mhz);
    assign sys_clk_src = src_q;
    assign flash_wait = ws_q;
    assign cpu_mhz = src_mhz;
    assign clk_fail_flag = fail_q;
    assign clk_fail_irq = fail_q & fail_irq_en;

    // prescalers; ahb feeds both apb dividers
    logic run_clks, ahb_tick, fast_tick, slow_tick;
    assign run_clks = (pwr_q == PWR_RUN) || (pwr_q == PWR_SLEEP);

    clk_divider ahb_div_i (
        .sys_clk(sys_clk),
        .rst(any_rst),
        .src_en(1'b1),
        .run(run_clks),
        .div(ahb_div),
        .tick(ahb_tick)
    );
    clk_divider fast_div_i (
        .sys_clk(sys_clk),
        .rst(any_rst),
        .src_en(ahb_tick),
        .run(run_clks),
        .div(apb_fast_div),
        .tick(fast_tick)
    );
    clk_divider slow_div_i (
        .sys_clk(sys_clk),
        .rst(any_rst),
        .src_en(ahb_tick),
        .run(run_clks),
        .div(apb_slow_div),
        .tick(slow_tick)
    );

    // gated enables; sleep stops only the cpu
    always_comb begin
        clk_en.cpu_en = ahb_tick && (pwr_q == PWR_RUN);
        clk_en.ahb_en = ahb_tick;
        clk_en.apb_fast_en = fast_tick;
        clk_en.apb_slow_en = slow_tick;
        // timer clock runs off the undivided source, not the bus limit
        clk_en.adv_timer_en = run_clks;
    end

    // oscillator enables; low-speed clock for rtc/watchdog never stops
    assign rc_osc_on = ~any_rst & (pwr_q != PWR_STOP);
    assign ext_osc_on = ~any_rst & (pwr_q != PWR_STOP) &
                        (sw_clk_sel == 2'd1 || ext_used);
    assign pll_on = ~any_rst & (pwr_q != PWR_STOP) &
                    (sw_clk_sel == 2'd2 || src_q == SRC_PLL);
    assign lsclk_on = 1'b1;
    assign regulator_lp = (pwr_q == PWR_STOP) & stop_lp_regulator;

    // checks
    fallback_rc_a: assert property (
        @(posedge sys_clk) disable iff (any_rst)
        (ext_used && ext_fail) |=> (src_q == SRC_RC && fail_q))
        else $error("no fallback to rc on clock failure");
    ws_cover_a: assert property (
        @(posedge sys_clk) disable iff (any_rst)
        ws_q >= ws_for(src_mhz) || $changed(src_q))
        else $error("too few wait states for cpu clock");
    stop_gate_a: assert property (
        @(posedge sys_clk) disable iff (any_rst)
        (pwr_q == PWR_STOP) |-> !clk_en.ahb_en && !rc_osc_on && !pll_on)
        else $error("clock running in stop");
    sleep_cpu_a: assert property (
        @(posedge sys_clk) disable iff (any_rst)
        (pwr_q == PWR_SLEEP) |-> !clk_en.cpu_en)
        else $error("cpu clock running in sleep");
    irq_gate_a: assert property (
        @(posedge sys_clk) disable iff (any_rst)
        clk_fail_irq |-> fail_irq_en && fail_q)
        else $error("fail interrupt without enable");
    stop_wake_a: assert property (
        @(posedge sys_clk) disable iff (any_rst)
        (pwr_q == PWR_STOP && wake_ev) |=> pwr_q == PWR_WAKE)
        else $error("no wake from stop");
    wake_settle_a: assert property (
        @(posedge sys_clk) disable iff (any_rst)
        (pwr_q == PWR_WAKE && !rc_s2_q) |=> pwr_q == PWR_WAKE)
        else $error("left wake before rc stable");
    reset_src_a: assert property (
        @(posedge sys_clk) $fell(any_rst) |-> src_q == SRC_RC && ws_q == 2'd0)
        else $error("not on rc after reset");
    lsclk_a: assert property (
        @(posedge sys_clk) lsclk_on)
        else $error("low speed clock stopped");
endmodule

// ---- crpc_defines.svh ----
`ifndef CRPC_DEFINES_SVH
`define CRPC_DEFINES_SVH
// flash wait-state thresholds, in MHz
`define WS0_MAX_MHZ 8'd24
`define WS1_MAX_MHZ 8'd48
// bus frequency limits, in MHz
`define AHB_MAX_MHZ 8'd72
`define APB_FAST_MAX_MHZ 8'd72
`define APB_SLOW_MAX_MHZ 8'd36
`define ADV_TIMER_MAX_MHZ 8'd144
// nominal clock figures, in MHz
`define RC_OSC_MHZ 8'd8
// internal rc startup settle time in ns, cycle count at 100 MHz
`define RC_SETTLE_NS 2000
`define SYS_CLK_NS 10
`define RC_SETTLE_CYC ((`RC_SETTLE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
// clock monitor: max sys_clk cycles between external clock edges
`define EXT_MON_TIMEOUT 8'd64
// prescaler reset values (divide codes, 0 means divide by 1)
`define AHB_DIV_RST 4'h0
`define APB_DIV_RST 4'h0
// number of wake event lines
`define WAKE_LINES 22
`endif

// ---- crpc_pkg.sv ----
package crpc_pkg;
    typedef enum logic [1:0] {
        SRC_RC,
        SRC_EXT,
        SRC_PLL
    } clk_src_e;
    typedef enum logic [1:0] {
        BOOT_FLASH,
        BOOT_SYSMEM,
        BOOT_SRAM
    } boot_src_e;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_STOP,
        PWR_WAKE
    } pwr_state_e;
    typedef struct packed {
        logic [3:0] ahb_div;
        logic [3:0] apb_fast_div;
        logic [3:0] apb_slow_div;
    } presc_cfg_s;
    typedef struct packed {
        logic cpu_en;
        logic ahb_en;
        logic apb_fast_en;
        logic apb_slow_en;
        logic adv_timer_en;
    } clk_en_s;
endpackage

// ---- clk_divider.sv ----
`timescale 1ns/1ps
// one-cycle enable every (div+1) source enables; counts only when running
module clk_divider
    import crpc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic src_en,
    input wire logic run,
    input wire logic [3:0] div,
    // enable out
    output logic tick
);
    logic [3:0] cnt_q, cnt_d;

    // next count; a new divide value is compared with the running count at once
    always_comb begin
        cnt_d = cnt_q;
        tick = 1'b0;
        if (run && src_en) begin
            if (cnt_q >= div) begin
                cnt_d = 4'h0;
                tick = 1'b1;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ---- crpc_partner.sv ----
`timescale 1ns/1ps
`include "crpc_defines.svh"
// far side: reset pin driver, oscillators and wake sources
module crpc_partner (
    // clock
    input wire logic sys_clk,
    // bench commands
    input wire logic pin_low,
    input wire logic osc_stall,
    input wire logic [4:0] ev_idx,
    input wire logic ev_go,
    // device controls
    input wire logic rc_osc_on,
    input wire logic ext_osc_on,
    // pins
    output logic power_on_reset_pin_n,
    output logic ext_osc_clk,
    output logic rc_osc_ready,
    output logic [`WAKE_LINES-1:0] external_event_lines
);
    int rc_cnt = 0;
    // released pin floats up to the pull-up level
    assign power_on_reset_pin_n = !pin_low;
    assign external_event_lines = ev_go ? 22'h1 << ev_idx : 22'h0;
    // rc needs some cycles to settle after it is powered
    always @(posedge sys_clk) begin
        rc_cnt <= rc_osc_on ? rc_cnt + 1 : 0;
    end
    assign rc_osc_ready = rc_cnt > 20;
    // crystal only swings while enabled; a stall models a dead crystal
    initial begin
        ext_osc_clk = 1'h0;
        forever begin
            #31;
            if (ext_osc_on && !osc_stall) ext_osc_clk = !ext_osc_clk;
        end
    end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "crpc_defines.svh"
module tb_top
    import crpc_pkg::*;
;
    localparam int RS = 0, BT = 1, SR = 2, FW = 3, MZ = 4;
    localparam int PS = 5, OS = 6, FL = 7, EN = 8;
    typedef struct {int k; logic [7:0] v;} note_s;
    note_s notes[$];
    int miscompares = 0, compares = 0, i, n;
    int cnt [5];
    logic [31:0] lfsr_q = 32'h1096E;
    logic [7:0] m;
    logic [1:0] cur_src, cur_ws;
    logic sys_clk, rst, pin_low, osc_stall, ev_go, fail_irq_en, fail_clr;
    logic boot_select_pin, boot_option_bit, pll_src_ext, irq_or_event;
    logic sleep_req, stop_req, stop_lp_regulator;
    logic power_on_reset_pin_n, ext_osc_clk, rc_osc_ready;
    logic core_rst, rc_osc_on, ext_osc_on, pll_on, lsclk_on, regulator_lp;
    logic clk_fail_flag, clk_fail_irq;
    logic [1:0] sw_clk_sel, flash_wait;
    logic [7:0] ext_clk_mhz, pll_clk_mhz, cpu_mhz;
    logic [3:0] ahb_div, apb_fast_div, apb_slow_div;
    logic [4:0] ev_idx;
    logic [`WAKE_LINES-1:0] external_event_lines;
    boot_src_e boot_src;
    clk_src_e sys_clk_src;
    clk_en_s clk_en;
    pwr_state_e pwr_state;

    clock_reset_power_control u_clock_reset_power_control (
        .sys_clk, .rst, .power_on_reset_pin_n, .boot_select_pin,
        .boot_option_bit, .sw_clk_sel, .ext_clk_mhz, .pll_clk_mhz,
        .pll_src_ext, .ahb_div, .apb_fast_div, .apb_slow_div, .fail_irq_en,
        .fail_clr, .ext_osc_clk, .rc_osc_ready, .sleep_req, .stop_req,
        .stop_lp_regulator, .irq_or_event, .external_event_lines, .core_rst,
        .boot_src, .sys_clk_src, .clk_en, .flash_wait, .cpu_mhz, .rc_osc_on,
        .ext_osc_on, .pll_on, .lsclk_on, .regulator_lp, .pwr_state,
        .clk_fail_flag, .clk_fail_irq
    );
    crpc_partner u_crpc_partner (
        .sys_clk, .pin_low, .osc_stall, .ev_idx, .ev_go, .rc_osc_on,
        .ext_osc_on, .power_on_reset_pin_n, .ext_osc_clk, .rc_osc_ready,
        .external_event_lines
    );

    // 100 MHz system clock
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] probe(input int k);
        case (k)
            RS: probe = {7'h0, core_rst};
            BT: probe = {6'h0, boot_src};
            SR: probe = {6'h0, sys_clk_src};
            FW: probe = {6'h0, flash_wait};
            MZ: probe = cpu_mhz;
            PS: probe = {6'h0, pwr_state};
            OS: probe = {3'h0, rc_osc_on, ext_osc_on, pll_on, lsclk_on,
                         regulator_lp};
            FL: probe = {6'h0, clk_fail_irq, clk_fail_flag};
            default: probe = {3'h0, clk_en};
        endcase
    endfunction
    function automatic logic [1:0] ws_for(input logic [7:0] f);
        ws_for = (f <= 8'h18) ? 2'h0 : (f <= 8'h30) ? 2'h1 : 2'h2;
    endfunction
    // one lfsr step feeds every random field of the bench
    function automatic void rnd();
        lfsr_q = {lfsr_q[30:0],
                  lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic note(input int k, input logic [7:0] v);
        notes.push_back('{k, v});
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // bounded wait; running out ends the run as a failure
    task automatic wait_for(input int k, input logic [7:0] v, input int lim);
        for (n = 0; n < lim && probe(k) !== v; n++) begin
            @(posedge sys_clk);
            #1;
        end
        cmp(probe(k), v);
        if (probe(k) !== v) end_of_test();
    endtask
    task automatic do_reset(input logic bs, input logic bo);
        @(posedge sys_clk);
        rst <= 1'h1;
        boot_select_pin <= bs;
        boot_option_bit <= bo;
        sw_clk_sel <= 2'h0;
        osc_stall <= 1'h0;
        cyc(9);
        note(RS, 8'h1);
        note(SR, 8'h0);
        cyc(1);
        rst <= 1'h0;
        cyc(2);
        cur_src = 2'h0;
        cur_ws = 2'h0;
    endtask
    // wait states go up before a speed-up, down only after a slow-down
    task automatic switch_to(input logic [1:0] s, input logic [7:0] f);
        logic [1:0] w;
        w = ws_for(f);
        @(posedge sys_clk);
        sw_clk_sel <= s;
        @(posedge sys_clk);
        if (w > cur_ws) begin
            note(FW, {6'h0, w});
            note(SR, {6'h0, cur_src});
        end else begin
            note(SR, {6'h0, s});
            note(FW, {6'h0, cur_ws});
        end
        @(posedge sys_clk);
        note(SR, {6'h0, s});
        note(FW, {6'h0, w});
        note(MZ, f);
        cur_src = s;
        cur_ws = w;
    endtask

    // results are read one step after the edge they describe
    always @(posedge sys_clk) begin
        #1;
        while (notes.size() > 0) begin
            cmp(probe(notes[0].k), notes[0].v);
            void'(notes.pop_front());
        end
    end

    initial begin
        {rst, pin_low, osc_stall, ev_go, fail_irq_en, fail_clr} = 6'h20;
        {boot_select_pin, boot_option_bit, pll_src_ext, irq_or_event} = 4'h0;
        {sleep_req, stop_req, stop_lp_regulator, sw_clk_sel} = 5'h0;
        {ahb_div, apb_fast_div, apb_slow_div, ev_idx} = 17'h0;
        ext_clk_mhz = 8'h10;
        pll_clk_mhz = 8'h40;
        for (i = 0; i < 3; i++) begin
            do_reset(i != 0, i == 1);
            note(BT, i[7:0]);
            note(RS, 8'h0);
        end
        $display("test boot done");
        @(posedge sys_clk);
        pin_low <= 1'h1;
        wait_for(RS, 8'h1, 4);
        repeat (20) begin
            @(posedge sys_clk);
            note(RS, 8'h1);
        end
        pin_low <= 1'h0;
        wait_for(RS, 8'h0, 5);
        $display("test reset pin done");
        for (i = 0; i < 4; i++) begin
            m = i == 0 ? 8'h40 : i == 1 ? 8'h30 : i == 2 ? 8'h18 : 8'h31;
            @(posedge sys_clk);
            pll_clk_mhz <= m;
            switch_to(2'h2, m);
            switch_to(2'h0, 8'h08);
        end
        @(posedge sys_clk);
        sw_clk_sel <= 2'h3;
        cyc(3);
        note(SR, 8'h0);
        $display("test switching done");
        for (i = 0; i < 2; i++) begin
            rnd();
            m = 8'h04 + lfsr_q[7:0] % 8'h1D;
            @(posedge sys_clk);
            ext_clk_mhz <= m;
            pll_clk_mhz <= 8'h40;
            pll_src_ext <= i[0];
            fail_irq_en <= i[0];
            switch_to(i ? 2'h2 : 2'h1, i ? 8'h40 : m);
            @(posedge sys_clk);
            osc_stall <= 1'h1;
            cyc(40);
            note(SR, {6'h0, cur_src});
            wait_for(SR, 8'h0, 40);
            cyc(3);
            note(FL, {6'h0, i[0], 1'h1});
            note(SR, 8'h0);
            @(posedge sys_clk);
            fail_clr <= 1'h1;
            sw_clk_sel <= 2'h0;
            @(posedge sys_clk);
            fail_clr <= 1'h0;
            @(posedge sys_clk);
            note(FL, 8'h0);
            do_reset(1'h0, 1'h0);
        end
        $display("test clock failure done");
        @(posedge sys_clk);
        sleep_req <= 1'h1;
        wait_for(PS, 8'h1, 4);
        @(posedge sys_clk);
        sleep_req <= 1'h0;
        cnt = '{0, 0, 0, 0, 0};
        repeat (16) begin
            @(posedge sys_clk);
            #1;
            cnt[0] += clk_en.cpu_en;
            cnt[1] += clk_en.ahb_en;
        end
        cmp(cnt[0][7:0], 8'h0);
        cmp(cnt[1][7:0], 8'h10);
        @(posedge sys_clk);
        irq_or_event <= 1'h1;
        wait_for(PS, 8'h0, 4);
        @(posedge sys_clk);
        irq_or_event <= 1'h0;
        $display("test sleep done");
        for (i = 0; i < 2; i++) begin
            rnd();
            @(posedge sys_clk);
            stop_req <= 1'h1;
            stop_lp_regulator <= i[0];
            ev_idx <= lfsr_q[9:5] % 5'h16;
            wait_for(PS, 8'h2, 4);
            @(posedge sys_clk);
            stop_req <= 1'h0;
            note(OS, {6'h1, i[0]});
            note(EN, 8'h0);
            @(posedge sys_clk);
            ev_go <= 1'h1;
            wait_for(PS, 8'h3, 6);
            @(posedge sys_clk);
            ev_go <= 1'h0;
            note(SR, 8'h0);
            cyc(150);
            note(PS, 8'h3);
            note(EN, 8'h0);
            wait_for(PS, 8'h0, 90);
        end
        $display("test stop done");
        rnd();
        @(posedge sys_clk);
        ahb_div <= {2'h0, lfsr_q[1:0]};
        apb_fast_div <= {2'h0, lfsr_q[3:2]};
        apb_slow_div <= {2'h0, lfsr_q[5:4]};
        cyc(80);
        n = 2 * (lfsr_q[1:0] + 1) * (lfsr_q[3:2] + 1) * (lfsr_q[5:4] + 1);
        cnt = '{0, 0, 0, 0, 0};
        repeat (n) begin
            @(posedge sys_clk);
            #1;
            cnt[1] += clk_en.ahb_en;
            cnt[2] += clk_en.apb_fast_en;
            cnt[3] += clk_en.apb_slow_en;
            cnt[4] += clk_en.adv_timer_en;
        end
        m = 8'(n / (lfsr_q[1:0] + 1));
        cmp(cnt[1][7:0], m);
        cmp(cnt[2][7:0], 8'(m / (lfsr_q[3:2] + 1)));
        cmp(cnt[3][7:0], 8'(m / (lfsr_q[5:4] + 1)));
        cmp(cnt[4][7:0], 8'(n));
        $display("test prescalers done");
        cyc(3);
        end_of_test();
    end
endmodule
